// ---- bcg_glue.sv ----
// glue between the multiplexed bcd converter and a serial link
//
// Local design decisions: the address-and-strobe port and the address map.
module bcg_glue (
	input  wire logic                       ref_clk,              // system clock
	input  wire logic                       sys_rst,              // async reset, high
	input  wire logic [bcg_pkg::ADDR_W-1:0] reg_addr,             // register index
	input  wire logic [bcg_pkg::DATA_W-1:0] reg_wdata,            // write data
	input  wire logic                       reg_wr,               // write strobe
	input  wire logic                       reg_rd,               // read strobe
	output logic      [bcg_pkg::DATA_W-1:0] reg_rdata,            // read data, next cycle
	output logic                            irq,                  // level interrupt
	input  wire logic                       strobe_n,             // converter strobe, low
	input  wire logic                       conv_busy,            // converter integrating
	input  wire logic                       polarity,             // 1 positive reading
	input  wire logic                       overrange,            // over range flag
	input  wire logic                       underrange,           // under range flag
	input  wire logic                       top_digit_select,     // most significant digit
	input  wire logic [3:0]                 digit_select,         // lower digits, [0] lowest
	input  wire logic                       bcd_weight_one,       // bcd bit 1
	input  wire logic                       bcd_weight_two,       // bcd bit 2
	input  wire logic                       bcd_weight_four,      // bcd bit 4
	input  wire logic                       bcd_weight_eight,     // bcd bit 8
	output logic                            run_hold,             // 1 run, 0 hold
	input  wire logic                       serial_receive_input, // serial command line
	output logic                            serial_tx_out         // serial data out
);
	localparam int SYNC_W = 15;
	// strobe and serial line reset to their idle high level, so no false edge
	localparam logic [SYNC_W-1:0] SYNC_RST = 15'h4001;

	////////////////////////////////////////////////////////////////////////////////
	// input synchronisers

	logic [SYNC_W-1:0] raw, meta_r, sync_r;
	assign raw = {serial_receive_input, bcd_weight_eight, bcd_weight_four,
		bcd_weight_two, bcd_weight_one, top_digit_select, digit_select,
		underrange, overrange, polarity, conv_busy, strobe_n};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++)
		begin : g_sync
			always_ff @(posedge ref_clk or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					meta_r[gi] <= SYNC_RST[gi];
					sync_r[gi] <= SYNC_RST[gi];
				end
				else
				begin
					meta_r[gi] <= raw[gi];
					sync_r[gi] <= meta_r[gi];
				end
			end
		end
	endgenerate

	logic       s_strb_n, s_busy, s_pol, s_ovr, s_und, s_rx;
	logic [4:0] s_dsel;
	logic [3:0] s_bcd;
	assign s_strb_n = sync_r[0];
	assign s_busy   = sync_r[1];
	assign s_pol    = sync_r[2];
	assign s_ovr    = sync_r[3];
	assign s_und    = sync_r[4];
	assign s_dsel   = sync_r[9:5];
	assign s_bcd    = sync_r[13:10];
	assign s_rx     = sync_r[14];

	////////////////////////////////////////////////////////////////////////////////
	// command receiver

	bcg_pkg::bcg_rx_st_t rx_st_r, rx_st_nxt;
	logic [15:0] rx_cnt_r, rx_cnt_nxt;
	logic [3:0]  rx_bit_r, rx_bit_nxt;
	logic [8:0]  rx_sh_r, rx_sh_nxt;
	logic        rx_done;
	logic [15:0] baud_r, baud_nxt;

	always_comb
	begin
		rx_st_nxt  = rx_st_r;
		rx_cnt_nxt = rx_cnt_r;
		rx_bit_nxt = rx_bit_r;
		rx_sh_nxt  = rx_sh_r;
		rx_done    = 1'b0;
		unique case (rx_st_r)
			bcg_pkg::RX_IDLE:
				if (!s_rx)
				begin
					rx_cnt_nxt = {1'b0, baud_r[15:1]};
					rx_st_nxt  = bcg_pkg::RX_START;
				end
			bcg_pkg::RX_START:
				if (rx_cnt_r != 16'h0000)
					rx_cnt_nxt = rx_cnt_r - 16'h0001;
				else if (s_rx)
					rx_st_nxt = bcg_pkg::RX_IDLE;
				else
				begin
					rx_cnt_nxt = baud_r - 16'h0001;
					rx_bit_nxt = 4'h0;
					rx_st_nxt  = bcg_pkg::RX_BITS;
				end
			bcg_pkg::RX_BITS:
				if (rx_cnt_r != 16'h0000)
					rx_cnt_nxt = rx_cnt_r - 16'h0001;
				else
				begin
					rx_sh_nxt  = {s_rx, rx_sh_r[8:1]};
					rx_bit_nxt = rx_bit_r + 4'h1;
					rx_cnt_nxt = baud_r - 16'h0001;
					if (rx_bit_r == bcg_pkg::RX_LAST_BIT)
						rx_st_nxt = bcg_pkg::RX_STOP;
				end
			bcg_pkg::RX_STOP:
				if (rx_cnt_r != 16'h0000)
					rx_cnt_nxt = rx_cnt_r - 16'h0001;
				else
				begin
					rx_done   = s_rx;
					rx_st_nxt = bcg_pkg::RX_IDLE;
				end
			default: rx_st_nxt = bcg_pkg::RX_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rx_st_r  <= bcg_pkg::RX_IDLE;
			rx_cnt_r <= 16'h0000;
			rx_bit_r <= 4'h0;
			rx_sh_r  <= 9'h000;
		end
		else
		begin
			rx_st_r  <= rx_st_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			rx_bit_r <= rx_bit_nxt;
			rx_sh_r  <= rx_sh_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// word builder and converter control

	logic [2:0]              ctrl_r, ctrl_nxt;
	logic [bcg_pkg::IRQ_W-1:0] irq_en_r, irq_en_nxt, irq_st_r, irq_st_nxt, irq_ev, irq_clr;
	logic [7:0]  hold_r, hold_nxt, msd_r, msd_nxt;
	logic        pend_r, pend_nxt, cmd_r, cmd_nxt, rxpos_r, rxpos_nxt;
	logic        run_r, run_nxt, irq_r, irq_nxt;
	logic        strb_prev_r, busy_prev_r;
	logic [2:0]  wcnt_r, wcnt_nxt;
	logic        strobe_fall, busy_rise, complex_mode, tx_busy, tx_load;
	logic [3:0]  pfx, nib;
	logic [7:0]  word;

	assign complex_mode = ctrl_r[bcg_pkg::CTRL_COMPLEX];
	assign strobe_fall  = strb_prev_r & ~s_strb_n;
	assign busy_rise    = s_busy & ~busy_prev_r;
	assign tx_load      = pend_r & ~tx_busy;
	assign irq_clr      = (reg_wr && reg_addr == bcg_pkg::OFS_IRQ_CLR) ?
		reg_wdata[bcg_pkg::IRQ_W-1:0] : '0;

	always_comb
	begin
		pfx = bcg_pkg::PFX_D5;
		for (int i = 0; i < bcg_pkg::DIGITS; i++)
			if (s_dsel[i])
				pfx = bcg_pkg::PFX_TABLE[i*4 +: 4];
		nib = s_bcd;
		// top digit never exceeds 1, so the upper weights carry the flags
		if (complex_mode && s_dsel[4])
		begin
			nib[bcg_pkg::MSD_POL] = s_pol;
			nib[bcg_pkg::MSD_OVR] = s_ovr;
			nib[bcg_pkg::MSD_UND] = s_und;
		end
		word = {pfx, nib};
	end

	always_comb
	begin
		hold_nxt  = hold_r;
		pend_nxt  = pend_r;
		msd_nxt   = msd_r;
		wcnt_nxt  = wcnt_r;
		irq_ev    = '0;
		if (tx_load)
		begin
			pend_nxt                 = 1'b0;
			irq_ev[bcg_pkg::IRQ_WORD] = 1'b1;
		end
		if (strobe_fall)
		begin
			wcnt_nxt = s_dsel[4] ? 3'h1 : wcnt_r + 3'h1;
			if (wcnt_nxt == 3'(bcg_pkg::DIGITS))
				irq_ev[bcg_pkg::IRQ_READ] = 1'b1;
			if (s_dsel[4] && s_ovr)
				irq_ev[bcg_pkg::IRQ_OVR] = 1'b1;
			// an unsent byte is never overwritten; the newer word is dropped
			if (pend_r && !tx_load)
				irq_ev[bcg_pkg::IRQ_LOST] = 1'b1;
			else
			begin
				hold_nxt = word;
				pend_nxt = 1'b1;
			end
			if (s_dsel[4])
				msd_nxt = word;
		end
		cmd_nxt = cmd_r;
		if (busy_rise)
			cmd_nxt = 1'b0;
		rxpos_nxt = rxpos_r;
		if (rx_done && complex_mode)
		begin
			cmd_nxt                  = 1'b1;
			rxpos_nxt                = ~^rx_sh_r;
			irq_ev[bcg_pkg::IRQ_CMD] = 1'b1;
		end
		run_nxt = ~ctrl_r[bcg_pkg::CTRL_HOLD] &
			(complex_mode ? cmd_nxt : ctrl_r[bcg_pkg::CTRL_RUN]);
		irq_st_nxt = (irq_st_r & ~irq_clr) | irq_ev;
		irq_nxt    = |(irq_st_nxt & irq_en_r);
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			hold_r      <= 8'h00;
			pend_r      <= 1'b0;
			msd_r       <= 8'h00;
			wcnt_r      <= 3'h0;
			cmd_r       <= 1'b0;
			rxpos_r     <= 1'b0;
			run_r       <= 1'b0;
			irq_st_r    <= '0;
			irq_r       <= 1'b0;
			strb_prev_r <= 1'b1;
			busy_prev_r <= 1'b0;
		end
		else
		begin
			hold_r      <= hold_nxt;
			pend_r      <= pend_nxt;
			msd_r       <= msd_nxt;
			wcnt_r      <= wcnt_nxt;
			cmd_r       <= cmd_nxt;
			rxpos_r     <= rxpos_nxt;
			run_r       <= run_nxt;
			irq_st_r    <= irq_st_nxt;
			irq_r       <= irq_nxt;
			strb_prev_r <= s_strb_n;
			busy_prev_r <= s_busy;
		end
	end

	assign run_hold = run_r;
	assign irq      = irq_r;

	bcg_uart_tx #(
		.DIV_W (16)
	) u_tx (
		.ref_clk            (ref_clk),
		.sys_rst            (sys_rst),
		.load               (tx_load),
		.data               (hold_r),
		.even_parity_select (s_pol),
		.divisor            (baud_r),
		.busy               (tx_busy),
		.txd                (serial_tx_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	// register port

	logic [bcg_pkg::DATA_W-1:0] rdata_r, rdata_nxt;

	always_comb
	begin
		ctrl_nxt   = ctrl_r;
		irq_en_nxt = irq_en_r;
		baud_nxt   = baud_r;
		rdata_nxt  = '0;
		if (reg_wr)
		begin
			unique case (reg_addr)
				bcg_pkg::OFS_CTRL:   ctrl_nxt   = reg_wdata[2:0];
				bcg_pkg::OFS_IRQ_EN: irq_en_nxt = reg_wdata[bcg_pkg::IRQ_W-1:0];
				// a divisor below 4 cannot frame a bit; clamp it
				bcg_pkg::OFS_BAUD:   baud_nxt   = (reg_wdata < 16'h0004) ? 16'h0004 : reg_wdata;
				default:             ;
			endcase
		end
		if (reg_rd)
		begin
			unique case (reg_addr)
				bcg_pkg::OFS_CTRL:     rdata_nxt[2:0] = ctrl_r;
				bcg_pkg::OFS_STATUS:   rdata_nxt[10:0] = {wcnt_r, 1'b0, s_busy, s_und,
					s_ovr, s_pol, rxpos_r, cmd_r, pend_r | tx_busy};
				bcg_pkg::OFS_IRQ_STAT: rdata_nxt[bcg_pkg::IRQ_W-1:0] = irq_st_r;
				bcg_pkg::OFS_IRQ_EN:   rdata_nxt[bcg_pkg::IRQ_W-1:0] = irq_en_r;
				bcg_pkg::OFS_MSD:      rdata_nxt[7:0] = msd_r;
				bcg_pkg::OFS_BAUD:     rdata_nxt = baud_r;
				default:               rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctrl_r   <= bcg_pkg::CTRL_RST;
			irq_en_r <= '0;
			baud_r   <= bcg_pkg::BAUD_DIV_RST;
			rdata_r  <= '0;
		end
		else
		begin
			ctrl_r   <= ctrl_nxt;
			irq_en_r <= irq_en_nxt;
			baud_r   <= baud_nxt;
			rdata_r  <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;
endmodule

// ---- bcg_pkg.sv ----
// constants and types for the converter-to-serial glue
package bcg_pkg;
	localparam int          CLK_HZ       = 20_000_000;
	localparam int          BAUD_BPS     = 9600;
	localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / BAUD_BPS);
	localparam int          DATA_W       = 16;
	localparam int          ADDR_W       = 3;

	// register word indices
	localparam logic [2:0] OFS_CTRL     = 3'h0;
	localparam logic [2:0] OFS_STATUS   = 3'h1;
	localparam logic [2:0] OFS_IRQ_STAT = 3'h2;
	localparam logic [2:0] OFS_IRQ_EN   = 3'h3;
	localparam logic [2:0] OFS_IRQ_CLR  = 3'h4;
	localparam logic [2:0] OFS_MSD      = 3'h5;
	localparam logic [2:0] OFS_BAUD     = 3'h6;

	// control bits
	localparam int         CTRL_COMPLEX = 0;
	localparam int         CTRL_RUN     = 1;
	localparam int         CTRL_HOLD    = 2;
	localparam logic [2:0] CTRL_RST     = 3'h2;

	// interrupt bits
	localparam int         IRQ_WORD = 0;
	localparam int         IRQ_READ = 1;
	localparam int         IRQ_OVR  = 2;
	localparam int         IRQ_CMD  = 3;
	localparam int         IRQ_LOST = 4;
	localparam int         IRQ_W    = 5;

	// digit prefixes, top digit first
	localparam int          DIGITS    = 5;
	localparam logic [3:0]  PFX_D5    = 4'h0;
	localparam logic [3:0]  PFX_D4    = 4'h8;
	localparam logic [3:0]  PFX_D3    = 4'h4;
	localparam logic [3:0]  PFX_D2    = 4'hC;
	localparam logic [3:0]  PFX_D1    = 4'h2;
	localparam logic [19:0] PFX_TABLE = {PFX_D5, PFX_D4, PFX_D3, PFX_D2, PFX_D1};

	// flag positions inside the top digit nibble
	localparam int MSD_POL = 1;
	localparam int MSD_OVR = 2;
	localparam int MSD_UND = 3;

	// serial frame: 8 data bits then parity, then stop
	localparam logic [3:0] RX_LAST_BIT = 4'h8;
	localparam logic [3:0] TX_LAST_BIT = 4'hA;

	typedef enum logic [3:0] {
		RX_IDLE  = 4'h1,
		RX_START = 4'h2,
		RX_BITS  = 4'h4,
		RX_STOP  = 4'h8
	} bcg_rx_st_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'h1,
		TX_SEND = 2'h2
	} bcg_tx_st_t;
endpackage

// ---- bcg_uart_tx.sv ----
// serial transmitter: start, 8 data lsb first, parity, stop
module bcg_uart_tx #(
	parameter int DIV_W = 16
) (
	input  wire logic             ref_clk,            // system clock
	input  wire logic             sys_rst,            // async reset, high
	input  wire logic             load,               // take data this cycle
	input  wire logic [7:0]       data,               // byte to send
	input  wire logic             even_parity_select, // 1 even, 0 odd
	input  wire logic [DIV_W-1:0] divisor,            // clocks per bit
	output logic                  busy,               // frame in progress
	output logic                  txd                 // serial line
);
	generate
		if (DIV_W < 4)
		begin : g_chk
			$error("divisor too narrow");
		end
	endgenerate

	bcg_pkg::bcg_tx_st_t st_r, st_nxt;
	logic [9:0]       frame_r, frame_nxt;
	logic [DIV_W-1:0] cnt_r, cnt_nxt;
	logic [3:0]       bit_r, bit_nxt;
	logic             txd_r, txd_nxt;
	logic             par;

	// parity is frozen into the frame at load time
	assign par  = even_parity_select ? ^data : ~^data;
	assign busy = (st_r == bcg_pkg::TX_SEND);
	assign txd  = txd_r;

	always_comb
	begin
		st_nxt    = st_r;
		frame_nxt = frame_r;
		cnt_nxt   = cnt_r;
		bit_nxt   = bit_r;
		txd_nxt   = txd_r;
		unique case (st_r)
			bcg_pkg::TX_IDLE:
			begin
				txd_nxt = 1'b1;
				if (load)
				begin
					frame_nxt = {1'b1, par, data};
					txd_nxt   = 1'b0;
					cnt_nxt   = divisor - 1'b1;
					bit_nxt   = 4'h0;
					st_nxt    = bcg_pkg::TX_SEND;
				end
			end
			bcg_pkg::TX_SEND:
			begin
				if (cnt_r != '0)
					cnt_nxt = cnt_r - 1'b1;
				else if (bit_r == bcg_pkg::TX_LAST_BIT)
					st_nxt = bcg_pkg::TX_IDLE;
				else
				begin
					txd_nxt   = frame_r[0];
					frame_nxt = {1'b1, frame_r[9:1]};
					bit_nxt   = bit_r + 4'h1;
					cnt_nxt   = divisor - 1'b1;
				end
			end
			default: st_nxt = bcg_pkg::TX_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_r    <= bcg_pkg::TX_IDLE;
			frame_r <= 10'h3FF;
			cnt_r   <= '0;
			bit_r   <= 4'h0;
			txd_r   <= 1'b1;
		end
		else
		begin
			st_r    <= st_nxt;
			frame_r <= frame_nxt;
			cnt_r   <= cnt_nxt;
			bit_r   <= bit_nxt;
			txd_r   <= txd_nxt;
		end
	end
endmodule

// ---- bcg_glue_props.sv ----
// assertions on the glue's register, command and serial ports
module bcg_glue_props (
	input logic        ref_clk,      // system clock
	input logic        sys_rst,      // async reset
	input logic [2:0]  reg_addr,     // register index
	input logic [15:0] reg_wdata,    // write data
	input logic        reg_wr,       // write strobe
	input logic        reg_rd,       // read strobe
	input logic [15:0] reg_rdata,    // read data
	input logic        irq,          // interrupt
	input logic        strobe_n,     // converter strobe
	input logic        conv_busy,    // converter busy
	input logic        run_hold,     // run command
	input logic        serial_tx_out // serial out
);
	logic [2:0]  ctrl_r, ctrl_nxt;
	logic [15:0] baud_r, baud_nxt, fcnt_r, fcnt_nxt;
	logic [6:0]  idle_r, idle_nxt;
	logic        tx_r;
	////////////////////////////////////////////////////////////////////////////////
	// shadow of control and bit time, frame position counter
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		baud_nxt = baud_r;
		fcnt_nxt = 16'h0000;
		if (reg_wr && reg_addr == bcg_pkg::OFS_CTRL)
			ctrl_nxt = reg_wdata[2:0];
		if (reg_wr && reg_addr == bcg_pkg::OFS_BAUD)
			baud_nxt = (reg_wdata < 16'h0004) ? 16'h0004 : reg_wdata;
		idle_nxt = !serial_tx_out ? 7'h00 : idle_r + {6'h00, idle_r != 7'h7F};
		if (fcnt_r != 16'h0000 && 32'(fcnt_r) < 11 * 32'(baud_r) - 1)
			fcnt_nxt = fcnt_r + 16'h0001;
		else if (fcnt_r == 16'h0000 && tx_r && !serial_tx_out)
			fcnt_nxt = 16'h0001;
	end
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctrl_r <= 3'h2;
			baud_r <= bcg_pkg::BAUD_DIV_RST;
			fcnt_r <= 16'h0000;
			idle_r <= 7'h00;
			tx_r   <= 1'h1;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			baud_r <= baud_nxt;
			fcnt_r <= fcnt_nxt;
			idle_r <= idle_nxt;
			tx_r   <= serial_tx_out;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// idle line demanded: a strobe during a frame waits for the frame to end, or is dropped if a byte already waits
	property p_word_start;
		$fell(strobe_n) && idle_r >= 7'h40 |-> ##[2:8] !serial_tx_out;
	endproperty
	a_word_start: assert property (p_word_start) else $error("no frame after strobe");
	property p_start_len;
		$fell(serial_tx_out) |-> !serial_tx_out [*4];
	endproperty
	a_start_len: assert property (p_start_len) else $error("start bit too short");
	property p_stop;
		fcnt_r == 10 * baud_r + baud_r / 2 |-> serial_tx_out;
	endproperty
	a_stop: assert property (p_stop) else $error("stop bit missing");
	property p_ctrl_run;
		(reg_wr && reg_addr == bcg_pkg::OFS_CTRL && !reg_wdata[0])
		##1 !(reg_wr && reg_addr == bcg_pkg::OFS_CTRL) |-> ##1 run_hold == (ctrl_r[1] && !ctrl_r[2]);
	endproperty
	a_ctrl_run: assert property (p_ctrl_run) else $error("run output wrong");
	property p_hold;
		ctrl_r[2] && $past(ctrl_r[2]) |-> !run_hold;
	endproperty
	a_hold: assert property (p_hold) else $error("runs while held");
	property p_busy_clear;
		ctrl_r[0] && $rose(conv_busy) |-> ##[2:8] !run_hold;
	endproperty
	a_busy_clear: assert property (p_busy_clear) else $error("busy left command");
	property p_rd_idle;
		!$past(reg_rd) |-> reg_rdata == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_irq_mask;
		(reg_wr && reg_addr == bcg_pkg::OFS_IRQ_EN && reg_wdata[4:0] == 5'h00)
		##1 !(reg_wr && reg_addr == bcg_pkg::OFS_IRQ_EN) |-> ##1 !irq;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt high");
endmodule
bind bcg_glue bcg_glue_props u_props (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .strobe_n(strobe_n),
	.conv_busy(conv_busy), .run_hold(run_hold), .serial_tx_out(serial_tx_out));

// ---- bcg_conv_model.sv ----
// behavioural converter: busy phase, then five digit scans each with a strobe
module bcg_conv_model #(
	parameter int BUSY_CY = 20,
	parameter int DIG_CY  = 128
) (
	input  logic        ref_clk,    // system clock
	input  logic        run_hold,   // 1 run
	input  logic        ovr_in,     // reading over range
	input  logic        und_in,     // reading under range
	input  logic [19:0] val_in,     // five bcd digits, top first
	output logic        strobe_n,   // strobe, low
	output logic        conv_busy,  // integrating
	output logic        overrange,  // over range flag
	output logic        underrange, // under range flag
	output logic [4:0]  sel,        // digit selects, [4] top
	output logic [3:0]  bcd         // bcd nibble
);
	initial
	begin
		strobe_n = 1'h1;
		conv_busy = 1'h0;
		overrange = 1'h0;
		underrange = 1'h0;
		sel = 5'h00;
		bcd = 4'h5;
		forever
		begin
			@(posedge ref_clk);
			if (run_hold === 1'h1)
			begin
				conv_busy <= 1'h1;
				repeat (BUSY_CY) @(posedge ref_clk);
				conv_busy <= 1'h0;
				overrange <= ovr_in;
				underrange <= und_in;
				for (int d = 0; d < 5; d++)
				begin
					sel <= 5'h10 >> d;
					bcd <= ovr_in ? 4'h0 : val_in[19-4*d -: 4];
					repeat (DIG_CY / 2) @(posedge ref_clk);
					strobe_n <= 1'h0;
					repeat (4) @(posedge ref_clk);
					strobe_n <= 1'h1;
					repeat (DIG_CY / 2 - 5) @(posedge ref_clk);
					sel <= 5'h00;
					// released lines show the inverse, never stale data
					bcd <= ~bcd;
					@(posedge ref_clk);
				end
			end
		end
	end
endmodule

// ---- bcg_glue_tb.sv ----
// self-checking bench for the converter-to-serial glue
module bcg_glue_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BD = 4;
	typedef struct packed {logic cpx; logic pol; logic ovr; logic und; logic [19:0] val;
		logic [7:0] msd;} bcg_row_t;
	logic        ref_clk, sys_rst, reg_wr, reg_rd, sri, pol, ovr, und, irq, stb_n, busy;
	logic        ovf, unf, run_hold, txd, ep;
	logic [2:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, q;
	logic [19:0] val;
	logic [4:0]  sel;
	logic [3:0]  bcd;
	logic [7:0]  eb;
	logic [8:0]  w;
	bcg_row_t    rows [4];
	bcg_row_t    r;
	int          bad_count, cmp_count;
	bcg_glue u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.irq(irq), .strobe_n(stb_n), .conv_busy(busy), .polarity(pol), .overrange(ovf),
		.underrange(unf), .top_digit_select(sel[4]), .digit_select(sel[3:0]),
		.bcd_weight_one(bcd[0]), .bcd_weight_two(bcd[1]), .bcd_weight_four(bcd[2]),
		.bcd_weight_eight(bcd[3]), .run_hold(run_hold), .serial_receive_input(sri),
		.serial_tx_out(txd));
	bcg_conv_model u_conv (.ref_clk(ref_clk), .run_hold(run_hold), .ovr_in(ovr), .und_in(und),
		.val_in(val), .strobe_n(stb_n), .conv_busy(busy), .overrange(ovf), .underrange(unf),
		.sel(sel), .bcd(bcd));
	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		#1;
		q = reg_rdata;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		if (got !== exp)
			bad_count++;
	endtask
	// bounded wait for a start bit, then mid-bit samples
	task automatic rx_word;
		int n;
		n = 0;
		while (txd !== 1'h0 && n < 2000)
		begin
			tick(1);
			n++;
		end
		if (n >= 2000)
			bad_count++;
		tick(BD / 2);
		for (int i = 0; i < 9; i++)
		begin
			tick(BD);
			w[i] = txd;
		end
		tick(BD);
		chk({15'h0000, txd}, 16'h0001);
	endtask
	task automatic cmd(input logic p);
		logic [10:0] f;
		f = {1'h1, p, 8'h55, 1'h0};
		for (int i = 0; i < 11; i++)
		begin
			@(posedge ref_clk);
			sri <= f[i];
			repeat (BD - 1) @(posedge ref_clk);
		end
	endtask
	task automatic print_verdict;
		if (bad_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		ref_clk = 1'h0;
		forever #25 ref_clk = ~ref_clk;
	end
	initial
	begin
		repeat (40000) @(posedge ref_clk);
		bad_count++;
		print_verdict;
	end
	initial
	begin
		{sys_rst, reg_wr, reg_rd, sri, pol, ovr, und} = 7'h49;
		reg_addr = 3'h0;
		reg_wdata = 16'h0000;
		val = 20'h00000;
		bad_count = 0;
		cmp_count = 0;
		rows = '{'{1'h0, 1'h1, 1'h0, 1'h0, 20'h12345, 8'h01},
			'{1'h0, 1'h0, 1'h0, 1'h0, 20'h09876, 8'h00},
			'{1'h1, 1'h1, 1'h0, 1'h1, 20'h10203, 8'h0B},
			'{1'h1, 1'h0, 1'h1, 1'h0, 20'h19999, 8'h04}};
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'h0;
		wr(bcg_pkg::OFS_BAUD, 16'h0001);
		rd(bcg_pkg::OFS_BAUD);
		chk(q, 16'h0004);
		wr(bcg_pkg::OFS_IRQ_EN, 16'h0002);
		foreach (rows[i])
		begin
			r = rows[i];
			@(posedge ref_clk);
			{pol, ovr, und, val} <= {r.pol, r.ovr, r.und, r.val};
			if (r.cpx)
				wr(bcg_pkg::OFS_CTRL, 16'h0001);
			if (r.cpx)
				cmd(~r.pol);
			else
				wr(bcg_pkg::OFS_CTRL, 16'h0002);
			if (!r.cpx)
				wr(bcg_pkg::OFS_CTRL, 16'h0006);
			for (int d = 0; d < 5; d++)
			begin
				rx_word;
				eb = {bcg_pkg::PFX_TABLE[19-4*d -: 4], r.ovr ? 4'h0 : r.val[19-4*d -: 4]};
				if (r.cpx && d == 0)
					eb[3:1] = {r.und, r.ovr, r.pol};
				ep = r.pol ? ^eb : ~^eb;
				chk({7'h00, w}, {7'h00, ep, eb});
			end
			tick(100);
			rd(bcg_pkg::OFS_MSD);
			chk(q, {8'h00, r.msd});
			rd(bcg_pkg::OFS_STATUS);
			chk({13'h0000, q[5:3]}, {13'h0000, r.und, r.ovr, r.pol});
			chk({13'h0000, q[10:8]}, 16'h0005);
			if (r.cpx)
				chk({15'h0000, q[2]}, {15'h0000, r.pol});
			rd(bcg_pkg::OFS_IRQ_STAT);
			chk(q, {12'h000, r.cpx, r.ovr, 2'h3});
			chk({15'h0000, irq}, 16'h0001);
			wr(bcg_pkg::OFS_IRQ_EN, 16'h0000);
			wr(bcg_pkg::OFS_IRQ_EN, 16'h0002);
			wr(bcg_pkg::OFS_IRQ_CLR, 16'h001F);
			tick(2);
			chk({15'h0000, irq}, 16'h0000);
		end
		// held complex link: command stays pending until hold is lifted
		wr(bcg_pkg::OFS_CTRL, 16'h0005);
		cmd(1'h1);
		tick(20);
		chk({15'h0000, run_hold}, 16'h0000);
		rd(bcg_pkg::OFS_STATUS);
		chk({15'h0000, q[1]}, 16'h0001);
		wr(bcg_pkg::OFS_CTRL, 16'h0001);
		tick(2);
		chk({15'h0000, run_hold}, 16'h0001);
		repeat (5) rx_word;
		rd(bcg_pkg::OFS_STATUS);
		chk({15'h0000, q[1]}, 16'h0000);
		// simple link ignores received words
		wr(bcg_pkg::OFS_IRQ_CLR, 16'h001F);
		wr(bcg_pkg::OFS_CTRL, 16'h0004);
		cmd(1'h1);
		tick(10);
		rd(bcg_pkg::OFS_IRQ_STAT);
		chk(q, 16'h0000);
		@(posedge ref_clk);
		sys_rst <= 1'h1;
		tick(2);
		chk({14'h0000, txd, run_hold}, 16'h0002);
		@(posedge ref_clk);
		sys_rst <= 1'h0;
		wr(3'h7, 16'hFFFF);
		rd(3'h7);
		chk(q, 16'h0000);
		rd(bcg_pkg::OFS_CTRL);
		chk(q, 16'h0002);
		rd(bcg_pkg::OFS_IRQ_EN);
		chk(q, 16'h0000);
		rd(bcg_pkg::OFS_BAUD);
		chk(q, bcg_pkg::BAUD_DIV_RST);
		print_verdict;
	end
endmodule
